// >>> core/adcsq_pkg.sv
// Package for the converter sequence status and result format block.
package adcsq_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_CONTROL_TWO   = 4'h2;
   localparam logic [3:0] ADDR_CONTROL_THREE = 4'h3;
   localparam logic [3:0] ADDR_CONTROL_FOUR  = 4'h4;
   localparam logic [3:0] ADDR_SEQ_START     = 4'h5;
   localparam logic [3:0] ADDR_SEQ_STATUS    = 4'h6;
   localparam logic [3:0] ADDR_RSVD_TEST     = 4'h8;
   localparam logic [3:0] ADDR_FORMAT_CFG    = 4'hA;
   localparam logic [3:0] ADDR_IRQ_STATUS    = 4'hC;
   localparam logic [3:0] ADDR_IRQ_MASK      = 4'hE;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_SEQ_DONE  = 7;
   localparam int BIT_TRIG_OVR  = 5;
   localparam int BIT_RES_OVR   = 4;
   localparam int CNT_MSB       = 2;
   // Format configuration register fields.
   localparam int BIT_LOW_RES   = 0;
   localparam int BIT_RJUST     = 1;
   localparam int BIT_SIGNED    = 2;
   localparam int BIT_FIFO      = 3;
   localparam int BIT_FAST_FLAG_CLEAR      = 4;
   localparam int BIT_SCAN      = 5;
   localparam int BIT_MULTI     = 6;
   localparam int BIT_TRIG_LVL  = 7;
   // Sequence start register: channel code in the low three bits.
   localparam int CHAN_MSB      = 2;
   // Interrupt event positions.
   localparam int IRQ_SEQ_DONE  = 0;
   localparam int IRQ_TRIG_OVR  = 1;
   localparam int IRQ_RES_OVR   = 2;

   localparam logic [7:0]  RESET_BYTE  = 8'h00;
   localparam logic [15:0] RESET_WORD  = 16'h0000;
   localparam logic [7:0]  TEST_RD_VAL = 8'h00;
   localparam logic [2:0]  CNT_ZERO    = 3'h0;
   localparam logic [2:0]  CNT_ONE     = 3'h1;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adcsq_bus_type;

   typedef struct packed {
      logic       valid;
      logic [9:0] code;
      logic [2:0] chan;
   } adcsq_conv_type;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_RUN  = 2'b01
   } adcsq_state_type;

endpackage : adcsq_pkg

// >>> core/adcsq_top.sv
// Sequence status, channel select and result formatting logic.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
//
// Contract
// - Results placed at bits 15..8, 15..6, 7..0 or 9..0 by format.
// - Right justified results are always unsigned; signed select ignored.
// - Left justified signed result is unsigned with MSB inverted.
// - Three bit channel code selects analog input zero through seven.
// - Sequence done flag, status bit 7, sets at each sequence end.
// - Done flag clears on write one, start write, or fast read clear.
// - Edge trigger during a running sequence sets overrun flag bit 5.
// - Trigger overrun clears on write one or control two..five write.
// - Result overrun bit 4 sets when writing an unacknowledged result.
// - Result overrun clears on write one or a written or triggered sequence start, not a scan restart.
// - Conversion counter in status bits 2..0, read only to software.
// - Without FIFO mode the counter zeroes at sequence start and end.
// - In FIFO mode the counter keeps running and wraps past seven.
// - Control two..five writes clear the counter even in FIFO mode.
// - Test register reads unpredictable; writes only in special mode.
// - Multi channel mode increments channel code, wrapping seven to zero.
// - Scan bit zero runs one sequence; one runs sequences continuously.
module adcsq_top (
   input  wire logic                   clk,          // 10 MHz clock
   input  wire logic                   sys_rst,      // Sync reset, high
   input  wire adcsq_pkg::adcsq_bus_type bus,        // Register request
   output logic [7:0]                  rdata,        // Read data
   input  wire logic                   special_mode, // Special mode strap
   input  wire logic                   ext_trig,     // Trigger pin
   input  wire logic                   conv_valid,   // Conversion done
   input  wire logic [9:0]             conv_code,    // Raw result code
   input  wire logic                   result_read,  // Result reg read
   input  wire logic [7:0]             ccf_flags,    // Done flags
   output logic [3:0]                  seq_len,      // Conversions/seq
   output logic                        conv_req,     // Converter request
   output logic [2:0]                  chan_sel,     // Channel code
   output logic [7:0]                  chan_onehot,  // Decoded input
   output logic [15:0]                 result_word,  // Formatted result
   output logic                        result_we,    // Result write
   output logic [2:0]                  result_idx,   // Target register
   output logic                        irq           // Interrupt level
);
   import adcsq_pkg::*;

   // -----------------------------------------------------------------
   // Helper functions
   // -----------------------------------------------------------------
   function automatic logic [15:0] fmt_result(input logic [9:0] code,
                                              input logic       low_res,
                                              input logic       rjust,
                                              input logic       sgn);
      logic [9:0] c;
      c = code;
      if (!rjust && sgn) begin
         if (low_res) c[9] = ~c[9];
         else         c[9] = ~c[9];
      end
      if (rjust) begin
         if (low_res) return {8'h00, code[9:2]};
         else         return {6'h00, code};
      end
      if (low_res) return {c[9:2], 8'h00};
      return {c, 6'h00};
   endfunction : fmt_result

   function automatic logic [7:0] decode_chan(input logic [2:0] code);
      decode_chan = 8'h01 << code;
   endfunction : decode_chan

   // -----------------------------------------------------------------
   // Register writes and configuration
   // -----------------------------------------------------------------
   logic [7:0] cfg_q;
   logic [7:0] test_q;
   logic [2:0] start_chan_q;
   logic [3:0] len_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic       sq_done_q;
   logic       trig_ovr_q;
   logic       res_ovr_q;
   logic [2:0] cnt_q;

   // Write decodes shared by the sequence control and the flags. An
   // abort write and a start write never meet in one cycle, as the bus
   // carries one address at a time.
   logic wr_start;   // Start a new sequence
   logic wr_abort;   // Control two, three or four write
   logic wr_status;  // Status register write
   logic wr_cfg;     // Format configuration write
   logic wr_len;     // Sequence length write
   logic wr_mask;    // Interrupt mask write
   logic wr_irq;     // Interrupt status write
   logic wr_test;    // Reserved test register write
   assign wr_start  = bus.wr && bus.addr == ADDR_SEQ_START;
   assign wr_abort  = bus.wr && (bus.addr == ADDR_CONTROL_TWO ||
                      bus.addr == ADDR_CONTROL_THREE ||
                      bus.addr == ADDR_CONTROL_FOUR);
   assign wr_status = bus.wr && bus.addr == ADDR_SEQ_STATUS;
   assign wr_cfg    = bus.wr && bus.addr == ADDR_FORMAT_CFG;
   assign wr_len    = bus.wr && bus.addr == ADDR_CONTROL_THREE;
   assign wr_mask   = bus.wr && bus.addr == ADDR_IRQ_MASK;
   assign wr_irq    = bus.wr && bus.addr == ADDR_IRQ_STATUS;
   assign wr_test   = bus.wr && bus.addr == ADDR_RSVD_TEST;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q        <= RESET_BYTE;
         start_chan_q <= CNT_ZERO;
         len_q        <= 4'h8;
         irq_mask_q   <= 3'h0;
      end else begin
         if (wr_cfg) begin
            cfg_q <= bus.wdata;
         end
         if (wr_len) begin
            len_q <= bus.wdata[3:0];
         end
         if (wr_start) begin
            start_chan_q <= bus.wdata[CHAN_MSB:0];
         end
         if (wr_mask) begin
            irq_mask_q <= bus.wdata[2:0];
         end
      end
   end

   // The mode strap is a pin and passes two stages before use.
   logic mode_s1_q, mode_s2_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
      end else begin
         mode_s1_q <= special_mode;
         mode_s2_q <= mode_s1_q;
      end
   end

   // Test register holds writes only while the part is in special mode.
   // In normal mode it reads as a fixed pattern; its read value is not
   // defined for software, so either choice is safe for a user.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         test_q <= RESET_BYTE;
      end else if (wr_test && mode_s2_q) begin
         test_q <= bus.wdata;
      end
   end

   // -----------------------------------------------------------------
   // Trigger input synchroniser and edge detect
   // -----------------------------------------------------------------
   logic trig_s1_q, trig_s2_q, trig_s3_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end else begin
         trig_s1_q <= ext_trig;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end
   logic trig_evt;
   assign trig_evt = cfg_q[BIT_TRIG_LVL] ? trig_s2_q
                                         : (trig_s2_q && !trig_s3_q);

   // -----------------------------------------------------------------
   // Sequence control
   // -----------------------------------------------------------------
   adcsq_state_type st_q;
   logic [3:0] done_cnt_q;
   logic [2:0] chan_q;
   logic       last_conv, seq_end, trig_start, seq_begin;

   assign last_conv  = conv_valid && st_q == SQ_RUN &&
                       done_cnt_q + 4'h1 >= len_q;
   assign seq_end    = last_conv && !wr_abort && !wr_start;
   assign trig_start = trig_evt && st_q == SQ_IDLE && !wr_start;
   assign seq_begin  = wr_start || trig_start;

   // An abort wins over a conversion finishing in the same cycle, so a
   // cut sequence never reports itself done.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q       <= SQ_IDLE;
         done_cnt_q <= 4'h0;
         chan_q     <= CNT_ZERO;
      end else if (wr_abort) begin
         st_q <= SQ_IDLE;
      end else if (seq_begin) begin
         st_q       <= SQ_RUN;
         done_cnt_q <= 4'h0;
         chan_q     <= wr_start ? bus.wdata[CHAN_MSB:0] : start_chan_q;
      end else if (conv_valid && st_q == SQ_RUN) begin
         if (cfg_q[BIT_MULTI]) begin
            chan_q <= chan_q + CNT_ONE;
         end
         if (last_conv) begin
            done_cnt_q <= 4'h0;
            if (cfg_q[BIT_SCAN]) begin
               chan_q <= start_chan_q;
            end else begin
               st_q <= SQ_IDLE;
            end
         end else begin
            done_cnt_q <= done_cnt_q + 4'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Conversion counter
   // -----------------------------------------------------------------
   // The counter names the register that the next result lands in. Any
   // control write clears it, so software sees a known value after one.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= CNT_ZERO;
      end else if (wr_abort || wr_start) begin
         cnt_q <= CNT_ZERO;
      end else if (!cfg_q[BIT_FIFO] && (trig_start || seq_end)) begin
         cnt_q <= CNT_ZERO;
      end else if (conv_valid && st_q == SQ_RUN) begin
         cnt_q <= cnt_q + CNT_ONE;
      end
   end

   // -----------------------------------------------------------------
   // Result output
   // -----------------------------------------------------------------
   // Strobe and data leave flip-flops together, one cycle after the
   // conversion, so the receiver always sees them aligned.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_word <= RESET_WORD;
         result_we   <= 1'b0;
         result_idx  <= CNT_ZERO;
      end else begin
         result_we <= conv_valid && st_q == SQ_RUN;
         if (conv_valid && st_q == SQ_RUN) begin
            result_idx  <= cnt_q;
            result_word <= fmt_result(conv_code, cfg_q[BIT_LOW_RES],
                                      cfg_q[BIT_RJUST], cfg_q[BIT_SIGNED]);
         end
      end
   end

   // -----------------------------------------------------------------
   // Status flags; a set in the same cycle as a write-one or fast read clear wins.
   // -----------------------------------------------------------------
   logic res_ovr_evt;   // Result written over an unacknowledged one
   logic trig_ovr_evt;  // Extra trigger edge while a sequence runs
   logic clr_done;      // Any clear of the sequence done flag
   logic clr_trig;      // Any clear of the trigger overrun flag
   logic clr_res;       // Any clear of the result overrun flag
   assign res_ovr_evt  = conv_valid && st_q == SQ_RUN && ccf_flags[cnt_q];
   assign trig_ovr_evt = !cfg_q[BIT_TRIG_LVL] && trig_evt &&
                         st_q == SQ_RUN && !wr_abort && !wr_start;

   // A zero in a flag position of a status write leaves that flag alone.
   assign clr_done = (wr_status && bus.wdata[BIT_SEQ_DONE]) || wr_start ||
                     (cfg_q[BIT_FAST_FLAG_CLEAR] && result_read);
   assign clr_trig = (wr_status && bus.wdata[BIT_TRIG_OVR]) || wr_abort ||
                     wr_start;
   assign clr_res  = (wr_status && bus.wdata[BIT_RES_OVR]) || seq_begin;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sq_done_q <= 1'b0;
      end else if (seq_end) begin
         sq_done_q <= 1'b1;
      end else if (clr_done) begin
         sq_done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_ovr_q <= 1'b0;
      end else if (trig_ovr_evt) begin
         trig_ovr_q <= 1'b1;
      end else if (clr_trig) begin
         trig_ovr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_ovr_q <= 1'b0;
      end else if (res_ovr_evt) begin
         res_ovr_q <= 1'b1;
      end else if (clr_res) begin
         res_ovr_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt status, write one to clear, set wins.
   // -----------------------------------------------------------------
   logic [2:0] irq_evt;
   assign irq_evt = {res_ovr_evt, trig_ovr_evt, seq_end};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_stat_q <= 3'h0;
      end else if (wr_irq) begin
         irq_stat_q <= (irq_stat_q & ~bus.wdata[2:0]) | irq_evt;
      end else begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   // Reads have no side effect on any flag; the fast clear comes from
   // the result read pin, not from this port.
   always_ff @(posedge clk) begin
      if (sys_rst) rdata <= RESET_BYTE;
      else if (bus.rd) begin
         unique case (bus.addr)
            ADDR_SEQ_STATUS: rdata <= {sq_done_q, 1'b0, trig_ovr_q,
                                       res_ovr_q, 1'b0, cnt_q};
            ADDR_RSVD_TEST:  rdata <= mode_s2_q ? test_q
                                                : TEST_RD_VAL;
            ADDR_FORMAT_CFG: rdata <= cfg_q;
            ADDR_CONTROL_THREE: rdata <= {4'h0, len_q};
            ADDR_SEQ_START:  rdata <= {5'h00, start_chan_q};
            ADDR_IRQ_STATUS: rdata <= {5'h00, irq_stat_q};
            ADDR_IRQ_MASK:   rdata <= {5'h00, irq_mask_q};
            default:         rdata <= RESET_BYTE;
         endcase
      end
   end

   assign seq_len     = len_q;
   assign conv_req    = st_q == SQ_RUN;
   assign chan_sel    = chan_q;
   assign chan_onehot = decode_chan(chan_q);

endmodule : adcsq_top

// >>> verif/adcsq_sva.sv
// Concurrent checks on the ports of the sequence status block.
`timescale 1ns/1ns
module adcsq_sva (
   input wire logic                     clk,         // Clock
   input wire logic                     sys_rst,     // Sync reset
   input wire logic                     special_mode, // Mode strap
   input wire adcsq_pkg::adcsq_bus_type bus,         // Register request
   input wire logic [7:0]               rdata,       // Read data
   input wire logic                     conv_valid,  // Conversion done
   input wire logic [3:0]               seq_len,     // Sequence length
   input wire logic                     conv_req,    // Running
   input wire logic [2:0]               chan_sel,    // Channel code
   input wire logic [7:0]               chan_onehot, // Decoded input
   input wire logic                     result_we,   // Result write
   input wire logic [2:0]               result_idx,  // Target register
   input wire logic                     irq          // Interrupt
);
   import adcsq_pkg::*;
   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire start_wr = bus.wr && bus.addr == ADDR_SEQ_START;
   wire abort_wr = bus.wr && bus.addr >= ADDR_CONTROL_TWO &&
                   bus.addr <= ADDR_CONTROL_FOUR;
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_reset_vals: assert property ($fell(sys_rst) |->
      seq_len == 4'h8 && !conv_req && !irq)
      else $error("Outputs wrong after reset.");
   chk_onehot_decode: assert property (
      chan_onehot == (8'h01 << chan_sel))
      else $error("Channel decode wrong.");
   chk_start_chan: assert property (start_wr |=>
      conv_req && chan_sel == $past(bus.wdata[2:0]))
      else $error("Start did not load channel.");
   chk_first_index: assert property (
      start_wr ##1 !conv_valid ##1 conv_valid |=>
      result_we && result_idx == 3'h0)
      else $error("First result not at index zero.");
   chk_abort_stops: assert property (abort_wr |=> !conv_req)
      else $error("Abort left sequence running.");
   chk_test_read: assert property (
      bus.rd && bus.addr == ADDR_RSVD_TEST && !special_mode &&
      !$past(special_mode) && !$past(special_mode, 2) &&
      !$past(special_mode, 3) |=> rdata == TEST_RD_VAL)
      else $error("Test register read wrong.");
   chk_unmapped_read: assert property (
      bus.rd && bus.addr == 4'h1 |=> rdata == 8'h00)
      else $error("Unmapped read not zero.");
   chk_we_cause: assert property (result_we |-> $past(conv_valid))
      else $error("Result write without conversion.");
   cover property (start_wr ##[1:20] result_we);
   cover property ($rose(irq));
   cover property (abort_wr ##1 !conv_req);
endmodule : adcsq_sva

bind adcsq_top adcsq_sva u_sva (.clk(clk), .sys_rst(sys_rst), .bus(bus),
   .special_mode(special_mode),
   .rdata(rdata), .conv_valid(conv_valid), .seq_len(seq_len),
   .conv_req(conv_req), .chan_sel(chan_sel), .chan_onehot(chan_onehot),
   .result_we(result_we), .result_idx(result_idx), .irq(irq));

// >>> verif/tb_top.sv
// Self-checking bench for the sequence status and format block.
`timescale 1ns/1ns
module tb_top;
   import adcsq_pkg::*;
   typedef struct packed {
      logic [7:0]  cfg;
      logic [9:0]  code;
      logic [15:0] exp;
   } adcsq_row_type;
   logic          clk = 1'b0;
   logic          sys_rst = 1'b1;
   adcsq_bus_type bus = '0;
   logic          ext_trig = 1'b0;
   logic          special_mode = 1'b0;
   logic          conv_valid = 1'b0;
   logic          result_read = 1'b0;
   logic [9:0]    conv_code = 10'h000;
   logic [7:0]    ccf_flags = 8'h00;
   logic [7:0]    rdata, chan_onehot;
   logic [3:0]    seq_len;
   logic          conv_req, result_we, irq;
   logic [2:0]    chan_sel, result_idx;
   logic [15:0]   result_word, w;
   int            n_fail = 0;
   int            total_checks = 0;
   adcsq_row_type rows [8] = '{'{8'h01, 10'h3FF, 16'hFF00},
      '{8'h05, 10'h3FF, 16'h7F00}, '{8'h05, 10'h000, 16'h8000},
      '{8'h07, 10'h3FF, 16'h00FF}, '{8'h00, 10'h3FF, 16'hFFC0},
      '{8'h04, 10'h3FF, 16'h7FC0}, '{8'h04, 10'h200, 16'h0000},
      '{8'h06, 10'h201, 16'h0201}};
   always #50 clk = ~clk;
   adcsq_top uut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
      .special_mode(special_mode), .ext_trig(ext_trig),
      .conv_valid(conv_valid),
      .conv_code(conv_code), .result_read(result_read),
      .ccf_flags(ccf_flags), .seq_len(seq_len), .conv_req(conv_req),
      .chan_sel(chan_sel), .chan_onehot(chan_onehot),
      .result_word(result_word), .result_we(result_we),
      .result_idx(result_idx), .irq(irq));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // Read data are looked at in the one cycle they are promised.
   task automatic rd(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(16'(rdata & m), 16'(e));
      @(posedge clk);
   endtask : rd
   task automatic cv(input logic [9:0] c);
      conv_valid <= 1'b1;
      conv_code  <= c;
      @(posedge clk);
      conv_valid <= 1'b0;
      #1 chk(16'(result_we), 16'h0001);
      w = result_word;
      @(posedge clk);
   endtask : cv
   task automatic seq8();
      wr(ADDR_SEQ_START, 8'h00);
      repeat (8) cv(10'h155);
   endtask : seq8
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h00);
      chk(16'(seq_len), 16'h0008);
      chk(16'(irq), 16'h0000);
      done("reset");
      foreach (rows[i]) begin
         wr(ADDR_FORMAT_CFG, rows[i].cfg);
         wr(ADDR_SEQ_START, 8'h00);
         cv(rows[i].code);
         chk(w, rows[i].exp);
      end
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_SEQ_START, 8'(i));
         chk(16'(chan_onehot), 16'h0001 << i);
      end
      wr(ADDR_FORMAT_CFG, 8'h40);
      wr(ADDR_SEQ_START, 8'h07);
      cv(10'h000);
      chk(16'(chan_sel), 16'h0000);
      done("format");
      wr(ADDR_FORMAT_CFG, 8'h00);
      seq8();
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h80);
      chk(16'(conv_req), 16'h0000);
      chk(16'(irq), 16'h0000);
      wr(ADDR_IRQ_MASK, 8'h01);
      chk(16'(irq), 16'h0001);
      wr(ADDR_IRQ_STATUS, 8'h01);
      chk(16'(irq), 16'h0000);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_SEQ_STATUS, 8'h00);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h80);
      wr(ADDR_SEQ_STATUS, 8'h80);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h00);
      wr(ADDR_FORMAT_CFG, 8'h10);
      seq8();
      result_read <= 1'b1;
      @(posedge clk);
      result_read <= 1'b0;
      @(posedge clk);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h00);
      seq8();
      wr(ADDR_SEQ_START, 8'h00);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h00);
      done("done flag");
      ccf_flags <= 8'hFF;
      cv(10'h001);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h11);
      wr(ADDR_SEQ_STATUS, 8'h07);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h11);
      wr(ADDR_SEQ_STATUS, 8'h10);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h01);
      cv(10'h001);
      wr(ADDR_SEQ_START, 8'h00);
      rd(ADDR_SEQ_STATUS, 8'hFF, 8'h00);
      ccf_flags <= 8'h00;
      done("overrun");
      wr(ADDR_CONTROL_TWO, 8'h00);
      ext_trig <= 1'b1;
      for (int i = 0; i < 20 && conv_req !== 1'b1; i++) @(posedge clk);
      chk(16'(conv_req), 16'h0001);
      for (int k = 0; k < 3; k++) begin
         repeat (4) @(posedge clk);
         ext_trig <= ~ext_trig;
      end
      repeat (4) @(posedge clk);
      rd(ADDR_SEQ_STATUS, 8'h20, 8'h20);
      wr(ADDR_CONTROL_TWO, 8'h00);
      rd(ADDR_SEQ_STATUS, 8'h20, 8'h00);
      wr(ADDR_RSVD_TEST, 8'h5A);
      rd(ADDR_RSVD_TEST, 8'hFF, 8'h00);
      special_mode <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_RSVD_TEST, 8'hFF, 8'h00);
      wr(ADDR_RSVD_TEST, 8'hA5);
      rd(ADDR_RSVD_TEST, 8'hFF, 8'hA5);
      special_mode <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_RSVD_TEST, 8'hFF, 8'h00);
      rd(4'h1, 8'hFF, 8'h00);
      done("trigger");
      wr(ADDR_CONTROL_THREE, 8'h03);
      chk(16'(seq_len), 16'h0003);
      wr(ADDR_FORMAT_CFG, 8'h28);
      wr(ADDR_SEQ_START, 8'h00);
      repeat (9) cv(10'h2AA);
      chk(16'(conv_req), 16'h0001);
      rd(ADDR_SEQ_STATUS, 8'h07, 8'h01);
      wr(ADDR_CONTROL_FOUR, 8'h00);
      rd(ADDR_SEQ_STATUS, 8'h07, 8'h00);
      done("fifo");
      report_and_stop();
   end
   // A hung handshake ends the run as a failure.
   initial begin
      #3000000;
      n_fail++;
      report_and_stop();
   end
endmodule : tb_top
